// ==== hw/dpo_pkg.sv ====
// package: constants, pin carriers and state types of the power-down / odt block
package dpo_pkg;

  // register map, byte addresses
  localparam logic [7:0] DPO_OFS_CTRL = 8'h00;
  localparam logic [7:0] DPO_OFS_STATUS = 8'h04;
  localparam logic [7:0] DPO_OFS_CLEAR = 8'h08;

  // ctrl field positions
  localparam int DPO_CTRL_A12_BIT = 0;
  localparam int DPO_CTRL_NOM_LSB = 1;
  localparam int DPO_CTRL_WR_LSB = 4;
  localparam int DPO_CTRL_CWL_LSB = 8;
  localparam int DPO_CTRL_AL_LSB = 16;

  // status field positions
  localparam int DPO_ST_STATE_LSB = 0;
  localparam int DPO_ST_DLL_ON_BIT = 4;
  localparam int DPO_ST_SYNC_BIT = 5;
  localparam int DPO_ST_RTT_BIT = 6;
  localparam int DPO_ST_RX_BIT = 7;
  localparam int DPO_ST_DLLRST_BIT = 8;
  localparam int DPO_ST_TERM_EN_BIT = 9;

  // clear register
  localparam int DPO_CLR_DLLRST_BIT = 0;

  // values after reset
  localparam logic DPO_RST_A12 = 1'b0;
  localparam logic [2:0] DPO_RST_NOM = 3'h0;
  localparam logic [1:0] DPO_RST_WR = 2'h0;
  localparam logic [4:0] DPO_RST_CWL = 5'h05;
  localparam logic [4:0] DPO_RST_AL = 5'h00;

  // cycle counts, in link clock cycles
  localparam logic [3:0] DPO_TCPDED_CK = 4'h1;
  localparam logic [4:0] DPO_ODT_LAT_OFFSET = 5'h02;
  localparam int DPO_ODT_HIST = 32;

  // pins sampled from the controller side
  typedef struct packed {
    logic ck;
    logic cke;
    logic odt;
    logic reset_n;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dpo_pins_t;

  // termination, latency and power-down exit settings held by software
  typedef struct packed {
    logic a12;
    logic [2:0] rtt_nom;
    logic [1:0] rtt_wr;
    logic [4:0] cwl;
    logic [4:0] al;
  } dpo_mode_t;

  typedef enum logic [2:0] {
    DPO_ST_RESET,
    DPO_ST_IDLE,
    DPO_ST_DRAIN,
    DPO_ST_PD_ACT,
    DPO_ST_PD_PRE
  } dpo_state_t;

endpackage

// ==== hw/dpo_sync.sv ====
// two flip-flop synchroniser, one stage pair per bit
module dpo_sync
  import dpo_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // meta_ff feeds only sync_ff
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_ff[i] <= 1'b0;
          sync_ff[i] <= 1'b0;
        end else begin
          meta_ff[i] <= async_in[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_ff;

endmodule

// ==== hw/dpo_top.sv ====
// power-down entry/exit and synchronous on-die termination control
//
// How it works
// - cke low with nop enters power-down
// - pending activate/precharge/refresh finish before power-down
// - banks closed precharge, else active power-down
// - receivers off after tcpded, keep ck/odt/cke/reset
// - precharge power-down a12 zero turns dll off
// - dll kept on otherwise, except in reset, fast exit
// - reset low leaves power-down into reset
// - cke high with nop exits power-down
// - odt ignored when disabled or self-refresh
// - any nominal or write termination bit enables
// - registered odt zero off, one on
// - termination never uses command decode
// - synchronous odt whenever dll on and locked
// - turn on/off odt latency after sampling
// - odt latency is cwl plus al minus two
//
// The address map and the address-and-strobe port are this design's own decisions.
module dpo_top
  import dpo_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ck,
  input wire logic cke,
  input wire logic odt,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_open,
  input wire logic op_busy,
  input wire logic dll_locked,
  input wire logic self_refresh,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic rtt_on,
  output logic cmd_rx_en,
  output logic dll_on,
  output logic in_reset,
  output logic pd_active,
  output logic pd_precharge,
  output logic dll_reset_req
);

  typedef struct packed {
    logic ck_prev;
    logic cke_q;
    logic odt_q;
    logic nop_q;
    logic seen_edge;
    dpo_state_t st;
    logic [3:0] cpded_cnt;
    logic entry_locked;
    logic dll_reset_req;
    logic [DPO_ODT_HIST-1:0] odt_hist;
    logic rtt_on;
    logic cmd_rx_en;
    logic dll_on;
    logic in_reset;
    logic pd_active;
    logic pd_precharge;
    dpo_mode_t mode;
    logic [31:0] rdata;
  } dpo_regs_t;

  dpo_pins_t pins_raw;
  dpo_pins_t pins_s;
  dpo_regs_t cur_ff;
  dpo_regs_t nxt_ff;

  assign pins_raw.ck = ck;
  assign pins_raw.cke = cke;
  assign pins_raw.odt = odt;
  assign pins_raw.reset_n = reset_n;
  assign pins_raw.cs_n = cs_n;
  assign pins_raw.ras_n = ras_n;
  assign pins_raw.cas_n = cas_n;
  assign pins_raw.we_n = we_n;

  // all pins share one delay so ck edges line up with their data
  dpo_sync #(
    .W($bits(dpo_pins_t))
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  logic ck_rise;
  logic nop_now;
  logic term_en;
  logic sync_mode;
  logic [4:0] odt_lat;
  logic [5:0] lat_sum;
  logic [DPO_ODT_HIST-1:0] hist_shift;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;

  always_comb begin
    ck_rise = pins_s.ck & ~cur_ff.ck_prev;
    // deselect, or nop with chip selected
    nop_now = pins_s.cs_n | (pins_s.ras_n & pins_s.cas_n & pins_s.we_n);
    // any termination field non-zero turns the feature on
    term_en = ((|cur_ff.mode.rtt_nom) | (|cur_ff.mode.rtt_wr)) & ~self_refresh;
    sync_mode = cur_ff.dll_on & dll_locked;
    lat_sum = {1'b0, cur_ff.mode.cwl} + {1'b0, cur_ff.mode.al};
    // below two would be an illegal setting; clamp to zero rather than wrap
    if (lat_sum > {1'b0, DPO_ODT_LAT_OFFSET}) begin
      odt_lat = 5'(lat_sum - {1'b0, DPO_ODT_LAT_OFFSET});
    end else begin
      odt_lat = 5'h00;
    end
    hist_shift = {cur_ff.odt_hist[DPO_ODT_HIST-2:0], pins_s.odt};
  end

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[DPO_CTRL_A12_BIT] = cur_ff.mode.a12;
    ctrl_word[DPO_CTRL_NOM_LSB +: 3] = cur_ff.mode.rtt_nom;
    ctrl_word[DPO_CTRL_WR_LSB +: 2] = cur_ff.mode.rtt_wr;
    ctrl_word[DPO_CTRL_CWL_LSB +: 5] = cur_ff.mode.cwl;
    ctrl_word[DPO_CTRL_AL_LSB +: 5] = cur_ff.mode.al;
    status_word = 32'h0000_0000;
    status_word[DPO_ST_STATE_LSB +: 3] = cur_ff.st;
    status_word[DPO_ST_DLL_ON_BIT] = cur_ff.dll_on;
    status_word[DPO_ST_SYNC_BIT] = sync_mode;
    status_word[DPO_ST_RTT_BIT] = cur_ff.rtt_on;
    status_word[DPO_ST_RX_BIT] = cur_ff.cmd_rx_en;
    status_word[DPO_ST_DLLRST_BIT] = cur_ff.dll_reset_req;
    status_word[DPO_ST_TERM_EN_BIT] = term_en;
  end

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.ck_prev = pins_s.ck;

    // register port: writes steer mode, reads answer one cycle later only
    nxt_ff.rdata = 32'h0000_0000;
    if (reg_wr && reg_addr == DPO_OFS_CTRL) begin
      nxt_ff.mode.a12 = reg_wdata[DPO_CTRL_A12_BIT];
      nxt_ff.mode.rtt_nom = reg_wdata[DPO_CTRL_NOM_LSB +: 3];
      nxt_ff.mode.rtt_wr = reg_wdata[DPO_CTRL_WR_LSB +: 2];
      nxt_ff.mode.cwl = reg_wdata[DPO_CTRL_CWL_LSB +: 5];
      nxt_ff.mode.al = reg_wdata[DPO_CTRL_AL_LSB +: 5];
    end
    if (reg_wr && reg_addr == DPO_OFS_CLEAR && reg_wdata[DPO_CLR_DLLRST_BIT]) begin
      nxt_ff.dll_reset_req = 1'b0;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        DPO_OFS_CTRL: nxt_ff.rdata = ctrl_word;
        DPO_OFS_STATUS: nxt_ff.rdata = status_word;
        default: nxt_ff.rdata = 32'h0000_0000;
      endcase
    end

    // everything pin-facing except the reset pin advances on link clock rising edges only
    if (ck_rise) begin
      nxt_ff.seen_edge = 1'b1;
      nxt_ff.cke_q = pins_s.cke;
      nxt_ff.nop_q = nop_now;
      // decision rests on odt pin, mode bits and self_refresh alone, no command decode
      nxt_ff.odt_q = pins_s.odt & term_en;
      nxt_ff.odt_hist = hist_shift;
      if (cur_ff.cpded_cnt != 4'h0) begin
        nxt_ff.cpded_cnt = cur_ff.cpded_cnt - 4'h1;
      end

      unique case (cur_ff.st)
        DPO_ST_RESET: begin
          if (pins_s.reset_n) begin
            nxt_ff.st = DPO_ST_IDLE;
          end
        end
        DPO_ST_IDLE: begin
          // a first edge has no history, so no entry is taken on it
          if (cur_ff.seen_edge && cur_ff.cke_q && !pins_s.cke && nop_now) begin
            nxt_ff.st = DPO_ST_DRAIN;
            nxt_ff.cpded_cnt = DPO_TCPDED_CK;
            nxt_ff.entry_locked = dll_locked;
          end
        end
        DPO_ST_DRAIN: begin
          if (pins_s.cke && nop_now) begin
            nxt_ff.st = DPO_ST_IDLE;
          end else if (!op_busy) begin
            // in-flight row ops finish before the low-power state
            nxt_ff.st = bank_open ? DPO_ST_PD_ACT : DPO_ST_PD_PRE;
          end
        end
        DPO_ST_PD_ACT, DPO_ST_PD_PRE: begin
          if (pins_s.cke && nop_now) begin
            nxt_ff.st = DPO_ST_IDLE;
          end
        end
        default: nxt_ff.st = DPO_ST_RESET;
      endcase

      // leaving power-down with an unlocked dll at entry asks for a dll reset
      if (cur_ff.st != DPO_ST_IDLE && cur_ff.st != DPO_ST_RESET && nxt_ff.st == DPO_ST_IDLE
          && !cur_ff.entry_locked) begin
        nxt_ff.dll_reset_req = 1'b1;
      end
    end

    // reset pin wins over any power-down state, no edge needed
    if (!pins_s.reset_n) begin
      nxt_ff.st = DPO_ST_RESET;
      nxt_ff.cpded_cnt = 4'h0;
      nxt_ff.odt_hist = '0;
      nxt_ff.odt_q = 1'b0;
    end

    // receivers drop once tcpded has run out; ck, cke, odt, reset stay live
    if (nxt_ff.st == DPO_ST_IDLE) begin
      nxt_ff.cmd_rx_en = 1'b1;
    end else if (nxt_ff.st == DPO_ST_RESET) begin
      nxt_ff.cmd_rx_en = 1'b0;
    end else begin
      nxt_ff.cmd_rx_en = (nxt_ff.cpded_cnt != 4'h0);
    end

    // dll frozen in reset and in precharge power-down with slow exit
    if (nxt_ff.st == DPO_ST_RESET) begin
      nxt_ff.dll_on = 1'b0;
    end else if (nxt_ff.st == DPO_ST_PD_PRE && !cur_ff.mode.a12) begin
      nxt_ff.dll_on = 1'b0;
    end else begin
      nxt_ff.dll_on = 1'b1;
    end

    // synchronous mode: delayed copy of the registered pin
    // outside it the registered pin is used directly; the far side keeps it low
    if (!term_en || nxt_ff.st == DPO_ST_RESET) begin
      nxt_ff.rtt_on = 1'b0;
    end else if (sync_mode) begin
      nxt_ff.rtt_on = nxt_ff.odt_hist[odt_lat];
    end else begin
      nxt_ff.rtt_on = nxt_ff.odt_q;
    end

    nxt_ff.in_reset = (nxt_ff.st == DPO_ST_RESET);
    nxt_ff.pd_active = (nxt_ff.st == DPO_ST_PD_ACT);
    nxt_ff.pd_precharge = (nxt_ff.st == DPO_ST_PD_PRE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_ff.ck_prev <= 1'b0;
      cur_ff.cke_q <= 1'b0;
      cur_ff.odt_q <= 1'b0;
      cur_ff.nop_q <= 1'b0;
      cur_ff.seen_edge <= 1'b0;
      cur_ff.st <= DPO_ST_RESET;
      cur_ff.cpded_cnt <= 4'h0;
      cur_ff.entry_locked <= 1'b0;
      cur_ff.dll_reset_req <= 1'b0;
      cur_ff.odt_hist <= '0;
      cur_ff.rtt_on <= 1'b0;
      cur_ff.cmd_rx_en <= 1'b0;
      cur_ff.dll_on <= 1'b0;
      cur_ff.in_reset <= 1'b1;
      cur_ff.pd_active <= 1'b0;
      cur_ff.pd_precharge <= 1'b0;
      cur_ff.mode.a12 <= DPO_RST_A12;
      cur_ff.mode.rtt_nom <= DPO_RST_NOM;
      cur_ff.mode.rtt_wr <= DPO_RST_WR;
      cur_ff.mode.cwl <= DPO_RST_CWL;
      cur_ff.mode.al <= DPO_RST_AL;
      cur_ff.rdata <= 32'h0000_0000;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign reg_rdata = cur_ff.rdata;
  assign rtt_on = cur_ff.rtt_on;
  assign cmd_rx_en = cur_ff.cmd_rx_en;
  assign dll_on = cur_ff.dll_on;
  assign in_reset = cur_ff.in_reset;
  assign pd_active = cur_ff.pd_active;
  assign pd_precharge = cur_ff.pd_precharge;
  assign dll_reset_req = cur_ff.dll_reset_req;

endmodule

// ==== testbench/dpo_ctl_model.sv ====
// controller-side model: link clock, cke, odt and commands
module dpo_ctl_model (
  input wire logic clk,
  output logic ck,
  output logic cke,
  output logic odt,
  output logic reset_n,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {ck, cke, odt, reset_n, cs_n, ras_n, cas_n, we_n} = 8'h0f;
  // free running: power-down needs a stable clock
  always #24 ck = ~ck;
  // only nop or one activate, never a busy op or a dll read
  task automatic cyc(input logic k, input logic o, input logic n);
    @(negedge ck);
    @(posedge clk);
    cke <= k;
    odt <= o;
    cs_n <= n;
    ras_n <= n;
    @(posedge ck);
    // settle inside the high phase, before the next negedge
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic set_rn(input logic v);
    @(posedge clk);
    reset_n <= v;
  endtask
endmodule

// ==== testbench/dpo_top_monitor.sv ====
// assertions on the ports of the power-down and odt block
module dpo_top_monitor
  import dpo_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic bank_open,
  input wire logic op_busy,
  input wire logic self_refresh,
  input wire logic rtt_on,
  input wire logic cmd_rx_en,
  input wire logic dll_on,
  input wire logic in_reset,
  input wire logic pd_active,
  input wire logic pd_precharge
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic pd_any = pd_active | pd_precharge;
  sequence s_pd_enter;
    !pd_any ##1 pd_any;
  endsequence
  chk_rst_quiet: assert property (in_reset |-> !rtt_on && !pd_any && !cmd_rx_en)
    else $error("live output in reset");
  chk_pd_onehot: assert property (!(pd_active && pd_precharge))
    else $error("both power-down kinds");
  chk_pd_rx_off: assert property (s_pd_enter |-> ##[0:30] !cmd_rx_en)
    else $error("receivers stay on");
  chk_dll_kept: assert property (!pd_precharge && !in_reset |-> dll_on)
    else $error("dll off outside precharge pd");
  chk_pd_bank: assert property ($rose(pd_any) |-> pd_active == bank_open)
    else $error("wrong power-down kind");
  chk_busy_block: assert property (op_busy && $past(op_busy) |-> !$rose(pd_any))
    else $error("pd during busy op");
  chk_sr_rtt: assert property (self_refresh && $past(self_refresh) |-> !rtt_on)
    else $error("termination in self-refresh");
  chk_rst_pin: assert property ($fell(reset_n) |-> ##[1:8] in_reset)
    else $error("reset pin ignored");
endmodule

bind dpo_top dpo_top_monitor mon_u (.clk, .rst, .reset_n, .bank_open, .op_busy, .self_refresh, .rtt_on,
  .cmd_rx_en, .dll_on, .in_reset, .pd_active, .pd_precharge);

// ==== testbench/tb_dpo_top.sv ====
// self-checking bench for the power-down and odt block
module tb_dpo_top
  import dpo_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bank_open = 1'b0;
  logic op_busy = 1'b0;
  logic dll_locked = 1'b1;
  logic self_refresh = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic [31:0] d;
  logic ck, cke, odt, reset_n, cs_n, ras_n, cas_n, we_n;
  logic rtt_on, cmd_rx_en, dll_on, in_reset, pd_active, pd_precharge, dll_reset_req;
  int err_count = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;
  always #2.5 clk = ~clk;
  dpo_ctl_model ctl_u (.clk, .ck, .cke, .odt, .reset_n, .cs_n, .ras_n, .cas_n, .we_n);
  dpo_top dut_u (.clk, .rst, .ck, .cke, .odt, .reset_n, .cs_n, .ras_n, .cas_n, .we_n, .bank_open, .op_busy,
    .dll_locked, .self_refresh, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rtt_on, .cmd_rx_en,
    .dll_on, .in_reset, .pd_active, .pd_precharge, .dll_reset_req);
  task automatic final_report;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // busy held over three rises first, so the drain step is seen
  task automatic pd(input logic [31:0] c, input logic b, input logic l);
    wr(DPO_OFS_CTRL, c);
    bank_open <= b;
    dll_locked <= l;
    op_busy <= 1'b1;
    ctl_u.cyc(1'b1, 1'b0, 1'b1);
    repeat (2) ctl_u.cyc(1'b0, 1'b0, 1'b1);
    chk("busy drain", pd_active | pd_precharge, 1'b0);
    op_busy <= 1'b0;
    repeat (2) ctl_u.cyc(1'b0, 1'b0, 1'b1);
    chk("pd_active", pd_active, b);
    chk("pd_precharge", pd_precharge, !b);
    chk("dll_on pd", dll_on, b | c[0]);
    chk("rx_en pd", cmd_rx_en, 1'b0);
    ctl_u.cyc(1'b1, 1'b0, 1'b1);
    chk("rx_en exit", cmd_rx_en, 1'b1);
    chk("dll_reset_req", dll_reset_req, !l);
    dll_locked <= 1'b1;
  endtask
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 10000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(DPO_OFS_CTRL, d);
    chk("ctrl reset", d, 32'h0000_0500);
    chk("in_reset", in_reset, 1'b1);
    ctl_u.set_rn(1'b1);
    repeat (3) ctl_u.cyc(1'b1, 1'b0, 1'b1);
    chk("rx_en", cmd_rx_en, 1'b1);
    rd(8'h0c, d);
    chk("unmapped", d, 32'h0000_0000);
    for (int b = 0; b < 6; b++) begin
      wr(DPO_OFS_CTRL, 32'h0000_0500 | (32'h0000_0001 << b));
      rd(DPO_OFS_STATUS, d);
      chk("term_en", d[DPO_ST_TERM_EN_BIT], b != 0);
    end
    // m 0: al 0, m 1: al 2, m 2: termination disabled
    for (int m = 0; m < 3; m++) begin
      wr(DPO_OFS_CTRL, m == 2 ? 32'h0000_0500 : 32'h0000_0502 | (m << 17));
      for (int i = 0; i <= 4 + 2 * m; i++) begin
        ctl_u.cyc(1'b1, 1'b1, 1'b1);
        chk("rtt rise", rtt_on, m < 2 && i >= 3 + 2 * m);
      end
      for (int i = 0; i <= 4 + 2 * m; i++) begin
        ctl_u.cyc(1'b1, 1'b0, 1'b1);
        chk("rtt fall", rtt_on, m < 2 && i < 3 + 2 * m);
      end
    end
    wr(DPO_OFS_CTRL, 32'h0000_0502);
    repeat (5) ctl_u.cyc(1'b1, 1'b1, 1'b1);
    chk("rtt on", rtt_on, 1'b1);
    self_refresh <= 1'b1;
    ctl_u.cyc(1'b1, 1'b1, 1'b1);
    chk("rtt sr", rtt_on, 1'b0);
    self_refresh <= 1'b0;
    // unlocked dll leaves sync mode: rtt tracks the registered pin at once
    dll_locked <= 1'b0;
    ctl_u.cyc(1'b1, 1'b1, 1'b1);
    chk("rtt direct on", rtt_on, 1'b1);
    ctl_u.cyc(1'b1, 1'b0, 1'b1);
    chk("rtt direct off", rtt_on, 1'b0);
    dll_locked <= 1'b1;
    repeat (5) ctl_u.cyc(1'b1, 1'b0, 1'b1);
    ctl_u.cyc(1'b0, 1'b0, 1'b0);
    rd(DPO_OFS_STATUS, d);
    chk("no entry", d[2:0], DPO_ST_IDLE);
    ctl_u.cyc(1'b1, 1'b0, 1'b1);
    pd(32'h0000_0500, 1'b0, 1'b1);
    pd(32'h0000_0501, 1'b0, 1'b1);
    pd(32'h0000_0500, 1'b1, 1'b0);
    wr(DPO_OFS_CLEAR, 32'h0000_0001);
    #1;
    chk("dll_reset_req clr", dll_reset_req, 1'b0);
    bank_open <= 1'b0;
    repeat (2) ctl_u.cyc(1'b0, 1'b0, 1'b1);
    ctl_u.set_rn(1'b0);
    ctl_u.cyc(1'b0, 1'b0, 1'b1);
    chk("pd reset", {in_reset, pd_precharge}, 2'b10);
    ctl_u.set_rn(1'b1);
    repeat (2) ctl_u.cyc(1'b1, 1'b0, 1'b1);
    chk("reset left", in_reset, 1'b0);
    final_report();
  end
endmodule
